// ===== stm_defines.vh
// Register map, field positions and encodings of the standard timer
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define STM_ADDR_C0 3'h0
`define STM_ADDR_C1 3'h1
`define STM_ADDR_DL 3'h2
`define STM_ADDR_DH 3'h3
`define STM_ADDR_AL 3'h4
`define STM_ADDR_AH 3'h5
`define STM_ADDR_RP 3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STM_C0_PAU 7
`define STM_C0_CKS 6:4
`define STM_C0_ON 3
`define STM_C0_USED 7:3
`define STM_C1_MODE 7:6
`define STM_C1_PF 5:4
`define STM_C1_OC 3
`define STM_C1_POL 2
`define STM_C1_DPX 1
`define STM_C1_CCLR 0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define STM_MODE_CMP 2'h0
`define STM_MODE_CAP 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_TMR 2'h3
`define STM_PF_NONE 2'h0
`define STM_PF_LOW 2'h1
`define STM_PF_HIGH 2'h2
`define STM_PF_TOG 2'h3
`define STM_PF_ACT 2'h1
`define STM_PF_PWM 2'h2
`define STM_PF_SP 2'h3
`define STM_CAP_OFF 2'h3
`define STM_CAP_RISE 2'h0
`define STM_CAP_FALL 2'h1
`define STM_CK_SYS4 3'h0
`define STM_CK_SYS 3'h1
`define STM_CK_H16 3'h2
`define STM_CK_H64 3'h3
`define STM_CK_TBC 3'h4
`define STM_CK_H 3'h5
`define STM_CK_EXTR 3'h6
`define STM_CK_EXTF 3'h7

// ----------------------------------------
// Constants
// ----------------------------------------
`define STM_B0 8'h00
`define STM_C0_RSV 3'h0
`define STM_CNT0 16'h0000
`define STM_CNT1 16'h0001
`define STM_LOW_FF 8'hFF
`define STM_D4_LAST 2'h3
`define STM_H16_LAST 4'hF
`define STM_H64_LAST 6'h3F
`endif

// ===== stm_pin_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module stm_pin_sync
(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_resetn,
    // Pin
    input wire i_pin,
    // Filtered level and edges
    output wire o_level,
    output wire o_rise,
    output wire o_fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;
    reg rise_q;
    reg fall_q;

    // A change counts only once the second and third stages agree
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise_q <= (s2_q == s3_q) && s2_q && !lvl_q;
            fall_q <= (s2_q == s3_q) && !s2_q && lvl_q;
            if (s2_q == s3_q)
                lvl_q <= s2_q;
        end
    end

    assign o_level = lvl_q;
    assign o_rise = rise_q;
    assign o_fall = fall_q;
endmodule

// ===== stm_tick_gen.v
// Count clock selection and prescalers for the standard timer
`timescale 1ns/1ps
`include "stm_defines.vh"
module stm_tick_gen
(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_resetn,
    // Selection and sources
    input wire [2:0] i_sel,
    input wire i_hclk_tick,
    input wire i_tbc_tick,
    input wire i_ext_rise,
    input wire i_ext_fall,
    // Selected count event
    output reg o_tick
);
    reg [1:0] d4_q;
    reg [5:0] hdiv_q;

    // Prescalers run freely so a source change needs no restart
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            d4_q <= 2'h0;
            hdiv_q <= 6'h00;
        end
        else
        begin
            d4_q <= d4_q + 2'h1;
            if (i_hclk_tick)
                hdiv_q <= hdiv_q + 6'h01;
        end
    end

    always @*
    begin
        case (i_sel)
            `STM_CK_SYS4: o_tick = (d4_q == `STM_D4_LAST);
            `STM_CK_SYS: o_tick = 1'b1;
            `STM_CK_H16: o_tick = i_hclk_tick && (hdiv_q[3:0] == `STM_H16_LAST);
            `STM_CK_H64: o_tick = i_hclk_tick && (hdiv_q == `STM_H64_LAST);
            `STM_CK_TBC: o_tick = i_tbc_tick;
            `STM_CK_H: o_tick = i_hclk_tick;
            `STM_CK_EXTR: o_tick = i_ext_rise;
            `STM_CK_EXTF: o_tick = i_ext_fall;
            default: o_tick = 1'b0;
        endcase
    end
endmodule

// ===== stm_timer.v
// Standard 16-bit timer: registers, counter, comparators and pin logic
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "stm_defines.vh"

// Contract
// - Counter readable as two read-only bytes
// - Compare A is a read/write byte pair
// - Compare P is one 8-bit register
// - Pause holds counter, resume continues
// - Clock select picks one of eight sources
// - Run-enable rising edge zeroes the counter
// - Run-enable low halts, counter kept
// - Run rising restores initial pin level
// - Mode field selects four operating modes
// - Timer/counter mode releases the pin
// - Compare A match: none, low, high, toggle
// - Requested level equal initial: no change
// - PWM pin: inactive, active, PWM, pulse
// - Capture edge: rise, fall, both, off
// - Control 0 bits 2..0 read zero
// - Output control: initial or active level
// - Polarity bit inverts pin, not timer mode
// - Duty/period swap exchanges A and P roles
// - Clear on A match, or P/overflow
module stm_timer
(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_resetn,
    // Register port
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [7:0] o_rdata,
    // Internal clock events
    input wire i_hclk_tick,
    input wire i_tbc_tick,
    // External count pin
    input wire i_ext_count_pin,
    // Timer pin
    input wire i_timer_io_pin,
    output wire o_timer_io_pin,
    output wire o_timer_io_oe,
    // Match events
    output wire o_match_a,
    output wire o_match_p
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [7:3] ctl0_q;
    reg [7:0] ctl1_q;
    reg [15:0] cnt_q;
    reg [15:0] cmpa_q;
    reg [7:0] cmpp_q;
    reg run_prev_q;
    reg pin_q;
    reg sp_done_q;
    reg pwm_lvl_q;
    reg match_a_q;
    reg match_p_q;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg clear_hit;
    reg pwm_act;
    wire pause;
    wire run;
    wire run_rise;
    wire [1:0] mode;
    wire [1:0] pf;
    wire oc;
    wire pol;
    wire dpx;
    wire cclr;
    wire tick;
    wire step;
    wire hit_a;
    wire hit_p;
    wire [15:0] p_last;
    wire [15:0] p_span;
    wire ext_rise;
    wire ext_fall;
    wire io_rise;
    wire io_fall;
    wire cap_evt;

    assign pause = ctl0_q[`STM_C0_PAU];
    assign run = ctl0_q[`STM_C0_ON];
    assign mode = ctl1_q[`STM_C1_MODE];
    assign pf = ctl1_q[`STM_C1_PF];
    assign oc = ctl1_q[`STM_C1_OC];
    assign pol = ctl1_q[`STM_C1_POL];
    assign dpx = ctl1_q[`STM_C1_DPX];
    assign cclr = ctl1_q[`STM_C1_CCLR];

    // ----------------------------------------
    // Pin synchronisers and count clock
    // ----------------------------------------
    stm_pin_sync u_ext_sync
    (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_pin(i_ext_count_pin),
        .o_level(),
        .o_rise(ext_rise),
        .o_fall(ext_fall)
    );

    stm_pin_sync u_io_sync
    (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_pin(i_timer_io_pin),
        .o_level(),
        .o_rise(io_rise),
        .o_fall(io_fall)
    );

    stm_tick_gen u_tick
    (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_sel(ctl0_q[`STM_C0_CKS]),
        .i_hclk_tick(i_hclk_tick),
        .i_tbc_tick(i_tbc_tick),
        .i_ext_rise(ext_rise),
        .i_ext_fall(ext_fall),
        .o_tick(tick)
    );

    // ----------------------------------------
    // Counter and comparators
    // ----------------------------------------
    // Counting needs the module on and not paused
    assign step = tick && run && !pause;
    assign run_rise = run && !run_prev_q;

    // P compares the high byte; zero means a full 65536-count span
    assign p_span = {cmpp_q, `STM_B0};
    assign p_last = p_span - `STM_CNT1;
    assign hit_a = step && (cnt_q == cmpa_q);
    assign hit_p = step && (cnt_q == p_last);

    always @*
    begin
        if (mode == `STM_MODE_PWM)
        begin
            // Period register picked by the swap bit
            if (dpx)
                clear_hit = hit_a;
            else
                clear_hit = hit_p;
        end
        else if (cclr)
            clear_hit = hit_a;
        else
            clear_hit = hit_p;
    end

    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt_q <= `STM_CNT0;
            run_prev_q <= 1'b0;
            match_a_q <= 1'b0;
            match_p_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= run;
            match_a_q <= hit_a;
            match_p_q <= hit_p && !(cclr && mode != `STM_MODE_PWM);
            if (run_rise)
                cnt_q <= `STM_CNT0;
            else if (clear_hit)
                cnt_q <= `STM_CNT0;
            else if (step)
                cnt_q <= cnt_q + `STM_CNT1;
        end
    end

    // ----------------------------------------
    // PWM active level
    // ----------------------------------------
    // Duty at or beyond the period gives a 100 percent waveform
    always @*
    begin
        if (dpx)
            pwm_act = (cmpp_q == `STM_B0) || (cnt_q < p_span);
        else
            pwm_act = cnt_q < cmpa_q;
    end

    // ----------------------------------------
    // Output pin state
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_q <= 1'b0;
            sp_done_q <= 1'b0;
            pwm_lvl_q <= 1'b0;
        end
        else
        begin
            if (run_rise)
            begin
                pin_q <= oc;
                sp_done_q <= 1'b0;
            end
            else if (hit_a && mode == `STM_MODE_CMP)
            begin
                // A level equal to the present one leaves the pin as is
                case (pf)
                    `STM_PF_NONE: pin_q <= pin_q;
                    `STM_PF_LOW: pin_q <= 1'b0;
                    `STM_PF_HIGH: pin_q <= 1'b1;
                    `STM_PF_TOG: pin_q <= !pin_q;
                    default: pin_q <= pin_q;
                endcase
            end
            // Single pulse ends at the first period end and stays off
            if (mode == `STM_MODE_PWM && pf == `STM_PF_SP && clear_hit)
                sp_done_q <= 1'b1;
            case (pf)
                `STM_PF_NONE: pwm_lvl_q <= 1'b0;
                `STM_PF_ACT: pwm_lvl_q <= 1'b1;
                `STM_PF_PWM: pwm_lvl_q <= run && pwm_act;
                `STM_PF_SP: pwm_lvl_q <= run && pwm_act && !sp_done_q;
                default: pwm_lvl_q <= 1'b0;
            endcase
        end
    end

    // Level seen at the pin before the polarity bit
    reg pin_raw;
    always @*
    begin
        case (mode)
            `STM_MODE_CMP: pin_raw = pin_q;
            `STM_MODE_PWM: pin_raw = oc ? pwm_lvl_q : !pwm_lvl_q;
            default: pin_raw = 1'b0;
        endcase
    end

    // Timer/counter and capture modes leave the pin to others
    assign o_timer_io_oe = (mode == `STM_MODE_CMP) || (mode == `STM_MODE_PWM);
    assign o_timer_io_pin = o_timer_io_oe ? (pin_raw ^ pol) : 1'b0;

    // ----------------------------------------
    // Capture
    // ----------------------------------------
    // Captured count lands in compare A, which software then reads
    assign cap_evt = (mode == `STM_MODE_CAP) && run &&
        ((pf == `STM_CAP_RISE && io_rise) ||
         (pf == `STM_CAP_FALL && io_fall) ||
         (pf == `STM_PF_HIGH && (io_rise || io_fall)));

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Mode and pin function writes take effect at once; software
    // must stop the timer first or the waveform may glitch
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctl0_q <= 5'h00;
            ctl1_q <= `STM_B0;
            cmpa_q <= `STM_CNT0;
            cmpp_q <= `STM_B0;
        end
        else
        begin
            if (i_wr)
            begin
                case (i_addr)
                    `STM_ADDR_C0: ctl0_q <= i_wdata[`STM_C0_USED];
                    `STM_ADDR_C1: ctl1_q <= i_wdata;
                    `STM_ADDR_AL: cmpa_q[7:0] <= i_wdata;
                    `STM_ADDR_AH: cmpa_q[15:8] <= i_wdata;
                    `STM_ADDR_RP: cmpp_q <= i_wdata;
                    default: ctl0_q <= ctl0_q;
                endcase
            end
            // A capture wins over a write in the same cycle
            if (cap_evt)
                cmpa_q <= cnt_q;
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always @*
    begin
        case (i_addr)
            `STM_ADDR_C0: rdata_d = {ctl0_q, `STM_C0_RSV};
            `STM_ADDR_C1: rdata_d = ctl1_q;
            `STM_ADDR_DL: rdata_d = cnt_q[7:0];
            `STM_ADDR_DH: rdata_d = cnt_q[15:8];
            `STM_ADDR_AL: rdata_d = cmpa_q[7:0];
            `STM_ADDR_AH: rdata_d = cmpa_q[15:8];
            `STM_ADDR_RP: rdata_d = cmpp_q;
            default: rdata_d = `STM_B0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_q <= `STM_B0;
        else if (i_rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= `STM_B0;
    end

    assign o_rdata = rdata_q;
    assign o_match_a = match_a_q;
    assign o_match_p = match_p_q;
endmodule

// ===== stm_timer_sva.sv
// Port checker for the standard timer
`timescale 1ns/1ps
module stm_timer_sva
(
    // Clock, reset and register port
    input wire i_ref_clk,
    input wire i_resetn,
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Pin and match outputs
    input wire o_timer_io_pin,
    input wire o_timer_io_oe,
    input wire o_match_a,
    input wire o_match_p
);
// Shadow copies of the control registers, taken from bus writes
reg [7:0] c0_q;
reg [7:0] c1_q;
always @(posedge i_ref_clk or negedge i_resetn)
begin
    if (!i_resetn)
    begin
        c0_q <= 8'h00;
        c1_q <= 8'h00;
    end
    else if (i_wr && i_addr == 3'h0)
        c0_q <= i_wdata;
    else if (i_wr && i_addr == 3'h1)
        c1_q <= i_wdata;
end
wire stop = !c0_q[3] || c0_q[7];
wire nopwm = c1_q[0] && c1_q[7:6] != 2'h2;
default clocking cb @(posedge i_ref_clk);
endclocking
default disable iff (!i_resetn);
a_c0_unimpl: assert property (i_rd && i_addr == 3'h0 |=> o_rdata[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
a_c0_readback: assert property (i_wr && i_addr == 3'h0 ##2 i_rd && i_addr == 3'h0
    |=> o_rdata == ($past(i_wdata, 3) & 8'hF8)) else $error("control 0 readback");
a_cmpa_rw: assert property (i_wr && i_addr == 3'h4 && o_timer_io_oe ##2
    i_rd && i_addr == 3'h4 |=> o_rdata == $past(i_wdata, 3)) else $error("compare A readback");
a_cmpp_rw: assert property (i_wr && i_addr == 3'h6 ##2 i_rd && i_addr == 3'h6
    |=> o_rdata == $past(i_wdata, 3)) else $error("compare P readback");
a_tmr_release: assert property (c1_q[7:6] == 2'h3 |-> !o_timer_io_oe)
    else $error("pin driven in timer mode");
a_off_low: assert property (!o_timer_io_oe |-> !o_timer_io_pin)
    else $error("pin level while released");
a_cmp_drive: assert property (c1_q[7:6] == 2'h0 |-> o_timer_io_oe)
    else $error("pin not driven in compare mode");
a_run_rise_pin: assert property (i_wr && i_addr == 3'h0 && i_wdata[3] && !c0_q[3]
    && c1_q[7:6] == 2'h0 |-> ##3 o_timer_io_pin == (c1_q[3] ^ c1_q[2]))
    else $error("initial pin level");
a_cclr_no_p: assert property (nopwm ##1 nopwm |-> !o_match_p)
    else $error("compare P match with clear on A");
a_stop_quiet: assert property (stop ##1 stop ##1 stop |-> !o_match_a)
    else $error("match while stopped");
c_match_a: cover property (o_match_a);
c_match_p: cover property (o_match_p);
c_pwm_high: cover property (c1_q[7:6] == 2'h2 && o_timer_io_pin);
endmodule
bind stm_timer stm_timer_sva u_sva (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_timer_io_pin(o_timer_io_pin), .o_timer_io_oe(o_timer_io_oe),
    .o_match_a(o_match_a), .o_match_p(o_match_p));

// ===== tb.sv
// Self-checking bench for the standard timer
`timescale 1ns/1ps
module tb;
reg i_ref_clk = 1'b0;
reg i_resetn = 1'b0;
reg [2:0] i_addr = 3'h0;
reg [7:0] i_wdata = 8'h00;
reg i_wr = 1'b0;
reg i_rd = 1'b0;
reg i_tbc_tick = 1'b0;
reg i_hclk_tick = 1'b0;
reg i_ext_count_pin = 1'b0;
reg i_timer_io_pin = 1'b0;
wire [7:0] o_rdata;
wire o_timer_io_pin;
wire o_timer_io_oe;
integer bad_count = 0;
integer checked = 0;
integer cycles = 0;
integer i;
integer n;
reg [7:0] rv;
reg [7:0] r0;
// Expected deltas over 128 cycles per clock select, PWM rows, capture edge modes
reg [63:0] ctab = {8'h10, 8'h10, 8'h40, 8'h60, 8'h01, 8'h04, 8'h80, 8'h20};
reg [11:0] cpf = {2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3};
reg [55:0] ptab = {8'hA0, 8'hB8, 8'hAA, 8'hAC, 8'hA8, 8'h98, 8'h88};
reg [55:0] pexp = {8'h60, 8'h00, 8'h80, 8'h60, 8'h20, 8'h80, 8'h00};
stm_timer uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_hclk_tick(i_hclk_tick), .i_tbc_tick(i_tbc_tick), .i_ext_count_pin(i_ext_count_pin),
    .i_timer_io_pin(i_timer_io_pin), .o_timer_io_pin(o_timer_io_pin),
    .o_timer_io_oe(o_timer_io_oe), .o_match_a(), .o_match_p());
always #20 i_ref_clk = ~i_ref_clk;
// Ext pin period is 8 cycles; high-speed tick every other cycle, time-base 3 in 4
always @(posedge i_ref_clk)
begin
    cycles <= cycles + 1;
    i_hclk_tick <= ~i_hclk_tick;
    i_tbc_tick <= (cycles % 4 != 3);
    if (cycles % 4 == 3)
        i_ext_count_pin <= ~i_ext_count_pin;
    if (cycles == 20000)
    begin
        bad_count = bad_count + 1;
        results;
    end
end
task results;
begin
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
task chk(input [7:0] got, input [7:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task wr(input [2:0] a, input [7:0] d);
begin
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
end
endtask
task rd(input [2:0] a, output [7:0] d);
begin
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    d = o_rdata;
end
endtask
// Low-byte growth of the count over g cycles; the two reads are g apart
task delta(input integer g, output [7:0] d);
begin
    rd(3'h2, r0);
    repeat (g - 2) @(posedge i_ref_clk);
    rd(3'h2, d);
    d = d - r0;
end
endtask
task pin(input [7:0] e);
begin
    @(negedge i_ref_clk);
    chk({7'h00, o_timer_io_pin}, e);
end
endtask
initial
begin
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
        rd(i[2:0], rv);
        chk(rv, 8'h00);
    end
    wr(3'h0, 8'hFF);
    rd(3'h0, rv);
    chk(rv, 8'hF8);
    wr(3'h0, 8'h00);
    for (i = 4; i < 7; i = i + 1)
    begin
        wr(i[2:0], 8'h5A ^ i[7:0]);
        rd(i[2:0], rv);
        chk(rv, 8'h5A ^ i[7:0]);
    end
    wr(3'h2, 8'hFF);
    wr(3'h3, 8'hFF);
    rd(3'h2, rv);
    chk(rv, 8'h00);
    rd(3'h3, rv);
    chk(rv, 8'h00);
    wr(3'h1, 8'hC5);
    rd(3'h1, rv);
    chk(rv, 8'hC5);
    chk({7'h00, o_timer_io_oe}, 8'h00);
    wr(3'h1, 8'hC0);
    wr(3'h6, 8'h00);
    wr(3'h0, 8'h08);
    for (i = 0; i < 8; i = i + 1)
    begin
        wr(3'h0, {1'b0, i[2:0], 4'h8});
        repeat (8) @(posedge i_ref_clk);
        delta(128, rv);
        chk(rv, ctab[i * 8 +: 8]);
    end
    wr(3'h0, 8'h18);
    repeat (300) @(posedge i_ref_clk);
    wr(3'h0, 8'h98);
    delta(20, rv);
    chk(rv, 8'h00);
    wr(3'h0, 8'h18);
    delta(20, rv);
    chk(rv, 8'h14);
    wr(3'h0, 8'h10);
    delta(20, rv);
    chk(rv, 8'h00);
    wr(3'h0, 8'h18);
    rd(3'h3, rv);
    chk(rv, 8'h00);
    // ----------------------------------------
    // Compare pin: function, initial level, polarity
    // ----------------------------------------
    wr(3'h4, 8'h40);
    wr(3'h5, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
        wr(3'h0, 8'h10);
        wr(3'h1, {2'h0, i[1:0], i[2], i[0], 2'h1});
        wr(3'h0, 8'h18);
        // The run-enable edge is seen one clock after the write lands
        @(posedge i_ref_clk);
        pin({7'h00, i[2] ^ i[0]});
        repeat (100) @(posedge i_ref_clk);
        rv[0] = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h3) ? !i[2] : i[1];
        pin({7'h00, rv[0] ^ i[0]});
    end
    // ----------------------------------------
    // PWM and single pulse: half the high cycles over 256
    // ----------------------------------------
    wr(3'h6, 8'h01);
    for (i = 0; i < 7; i = i + 1)
    begin
        wr(3'h0, 8'h10);
        wr(3'h1, ptab[i * 8 +: 8]);
        wr(3'h0, 8'h18);
        if (i == 5)
        begin
            // Single pulse must be active at the start of its first period
            repeat (2) @(posedge i_ref_clk);
            pin(8'h01);
        end
        repeat (300) @(posedge i_ref_clk);
        n = 0;
        repeat (256)
        begin
            @(negedge i_ref_clk);
            n = n + o_timer_io_pin;
        end
        chk(n[8:1], pexp[i * 8 +: 8]);
    end
    // ----------------------------------------
    // Capture: a paused count lands in compare A
    // ----------------------------------------
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h70);
    wr(3'h0, 8'h18);
    repeat (20) @(posedge i_ref_clk);
    wr(3'h0, 8'h98);
    rd(3'h2, r0);
    for (i = 0; i < 6; i = i + 1)
    begin
        wr(3'h4, 8'hFF);
        wr(3'h1, {2'h1, cpf[i * 2 +: 2], 4'h0});
        @(posedge i_ref_clk);
        i_timer_io_pin <= ~i_timer_io_pin;
        repeat (10) @(posedge i_ref_clk);
        rd(3'h4, rv);
        chk(rv, (i == 0 || i > 3) ? 8'hFF : r0);
    end
    results;
end
endmodule
